/* hw/light_result_pkg.sv */
// ====================================================================
// Shared constants and carriers for the light result register bank.
// ====================================================================
package light_result_pkg;

  // ==================================================================
  // Register offsets, as seen by the serial register pointer.
  // ==================================================================
  localparam logic [7:0] OFS_CH0_W0 = 8'h00; // Range code, mantissa high.
  localparam logic [7:0] OFS_CH0_W1 = 8'h01; // Mantissa low, seq, check.
  localparam logic [7:0] OFS_CH1_W0 = 8'h02; // Range code, mantissa high.
  localparam logic [7:0] OFS_CH1_W1 = 8'h03; // Mantissa low, seq, check.

  // ==================================================================
  // Field widths and positions inside the 16-bit words.
  // ==================================================================
  localparam int unsigned WORD_W   = 16; // Register word width.
  localparam int unsigned CODE_W   = 4;  // Full-scale range code.
  localparam int unsigned MANT_W   = 20; // Whole mantissa.
  localparam int unsigned MHI_W    = 12; // Mantissa high part.
  localparam int unsigned MLO_W    = 8;  // Mantissa low part.
  localparam int unsigned SEQ_W    = 4;  // Rolling sample counter.
  localparam int unsigned CHK_W    = 4;  // Check bits.
  localparam int unsigned CODE_LSB = 12; // Code in word 0, bits 15-12.
  localparam int unsigned MHI_LSB  = 0;  // Mantissa high, bits 11-0.
  localparam int unsigned MLO_LSB  = 8;  // Mantissa low in word 1.
  localparam int unsigned SEQ_LSB  = 4;  // Counter in word 1, bits 7-4.
  localparam int unsigned CHK_LSB  = 0;  // Check in word 1, bits 3-0.

  // ==================================================================
  // Reset values.
  // ==================================================================
  localparam logic [15:0] WORD_RST     = 16'h0000; // Result words.
  localparam logic [15:0] UNMAPPED_VAL = 16'h0000; // Other offsets.
  localparam logic [7:0]  PTR_RST      = 8'h00;    // Read pointer.
  localparam logic [3:0]  SEQ_STEP     = 4'h1;     // Counter step.

  // One finished conversion of a channel.
  typedef struct packed {
    logic [3:0]  code; // Full-scale range code.
    logic [19:0] mant; // Mantissa.
  } conv_t;

  // Requests from the serial port engine, one cycle each.
  typedef struct packed {
    logic       ptr_wr; // Host wrote the register pointer.
    logic [7:0] ptr;    // Pointer value that was written.
    logic       rd;     // Host starts one two-byte register read.
    logic       stop;   // Stop condition seen on the bus.
  } host_req_t;

endpackage : light_result_pkg

/* hw/result_chan.sv */
`timescale 1ns/1ns
// ====================================================================
// One measurement channel: stores a conversion and its check bits.
// ====================================================================
module result_chan
  import light_result_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Conversion input.
  input  wire logic        conv_valid,
  input  wire conv_t       conv,
  // Register words.
  output logic [15:0]      word0,
  output logic [15:0]      word1
);

  logic [3:0]  code_r; // Stored range code.
  logic [19:0] mant_r; // Stored mantissa.
  logic [3:0]  seq_r;  // Rolling sample counter.
  logic [3:0]  chk_r;  // Stored check bits.
  logic [3:0]  seq_nxt; // Counter after this conversion.
  logic [3:0]  chk_nxt; // Check bits of the incoming conversion.

  // Check bits over code, mantissa and counter; the counter stands in
  // for the printed check field, which cannot feed its own equation.
  function automatic logic [3:0] chk_calc(input logic [3:0]  e,
                                          input logic [19:0] r,
                                          input logic [3:0]  c);
    logic [3:0] x;
    x    = '0;
    x[0] = ^e ^ ^r ^ ^c;
    x[1] = c[1] ^ c[3] ^ r[1] ^ r[3] ^ r[5] ^ r[7] ^ r[9] ^ r[11]
         ^ r[13] ^ r[15] ^ r[17] ^ r[19] ^ e[1] ^ e[3];
    x[2] = c[3] ^ r[3] ^ r[7] ^ r[11] ^ r[15] ^ r[19] ^ e[3];
    x[3] = r[3] ^ r[11] ^ r[19];
    return x;
  endfunction : chk_calc

  assign seq_nxt = seq_r + SEQ_STEP;
  assign chk_nxt = chk_calc(conv.code, conv.mant, seq_nxt);

  // All fields load in one edge so both words stay from one conversion.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= '0;
      mant_r <= '0;
      seq_r  <= '0;
      chk_r  <= '0;
    end else if (conv_valid) begin
      code_r <= conv.code;
      mant_r <= conv.mant;
      seq_r  <= seq_nxt;
      chk_r  <= chk_nxt;
    end
  end

  // Word layout; the mantissa splits twelve high and eight low bits.
  assign word0 = {code_r, mant_r[MANT_W-1 -: MHI_W]};
  assign word1 = {mant_r[MLO_W-1:0], seq_r, chk_r};

  seq_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    conv_valid |=> seq_r == $past(seq_r) + SEQ_STEP)
    else $error("sample counter did not advance by one");

  seq_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !conv_valid |=> $stable(seq_r) && $stable(mant_r))
    else $error("channel changed without a conversion");

endmodule : result_chan

/* hw/light_result_regs.sv */
`timescale 1ns/1ns
// ====================================================================
// Result registers of the first two light channels.
// ====================================================================
// Contract
// - Word 0 bits 15-12 hold range code.
// - Word 0 bits 11-0 hold mantissa high.
// - Word 1 bits 15-8 hold mantissa low.
// - Mantissa is high shifted eight plus low.
// - Bits 7-4 count conversions, rolling, reset zero.
// - Check bits 0 and 1 by XOR equations.
// - Check bits 2 and 3 by XOR equations.
// - Channel 1 repeats layout at offsets 2, 3.
// - Burst reads advance pointer; stop restores it.
module light_result_regs
  import light_result_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Conversions from the measurement engine.
  input  wire logic        conv_valid_ch0,
  input  wire conv_t       conv_ch0,
  input  wire logic        conv_valid_ch1,
  input  wire conv_t       conv_ch1,
  // Register read port of the serial engine.
  input  wire host_req_t   host_req,
  input  wire logic        burst_en,
  output logic [15:0]      rd_data_r,
  output logic             rd_valid_r
);

  // ==================================================================
  // Channel storage.
  // ==================================================================

  logic [15:0] ch0_w0; // Channel 0, word at offset 0.
  logic [15:0] ch0_w1; // Channel 0, word at offset 1.
  logic [15:0] ch1_w0; // Channel 1, word at offset 2.
  logic [15:0] ch1_w1; // Channel 1, word at offset 3.

  // Channel 0 sits at offsets 0 and 1.
  result_chan u_ch0 (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .conv_valid (conv_valid_ch0),
    .conv       (conv_ch0),
    .word0      (ch0_w0),
    .word1      (ch0_w1)
  );

  // Channel 1 is the same block at offsets 2 and 3.
  result_chan u_ch1 (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .conv_valid (conv_valid_ch1),
    .conv       (conv_ch1),
    .word0      (ch1_w0),
    .word1      (ch1_w1)
  );

  // ==================================================================
  // Read pointer.
  // ==================================================================

  logic [7:0] ptr_r;    // Current read pointer.
  logic [7:0] ptr_nxt;  // Next read pointer.
  logic [7:0] base_r;   // Pointer as last written by the host.
  logic [7:0] base_nxt; // Next base pointer.

  // A pointer write sets both copies. A stop puts the pointer back at
  // the base, and wins over a read in the same cycle because the read
  // that ends a burst must not leave a stale increment behind.
  assign base_nxt = host_req.ptr_wr ? host_req.ptr : base_r;
  assign ptr_nxt  = host_req.ptr_wr            ? host_req.ptr :
                    host_req.stop              ? base_r :
                    (host_req.rd && burst_en)  ? ptr_r + 8'h01 :
                    ptr_r;

  // Pointer registers.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r  <= PTR_RST;
      base_r <= PTR_RST;
    end else begin
      ptr_r  <= ptr_nxt;
      base_r <= base_nxt;
    end
  end

  // ==================================================================
  // Coherent snapshot of the second word.
  // ==================================================================

  logic        hit_w0;     // Read of a channel's first word.
  logic        hit_w1;     // Read of a channel's second word.
  logic        sel_ch1;    // The read addresses channel 1.
  logic [15:0] live_w1;    // Live second word of the addressed channel.
  logic        snap_hit;   // Snapshot belongs to this read.
  logic [15:0] snap_r;     // Second word caught with the first word.
  logic        snap_ch_r;  // Channel the snapshot belongs to.
  logic        snap_vld_r; // Snapshot is armed.
  logic        snap_vld_nxt; // Next armed state.

  assign hit_w0  = (ptr_r == OFS_CH0_W0) || (ptr_r == OFS_CH1_W0);
  assign hit_w1  = (ptr_r == OFS_CH0_W1) || (ptr_r == OFS_CH1_W1);
  assign sel_ch1 = (ptr_r == OFS_CH1_W0) || (ptr_r == OFS_CH1_W1);
  assign live_w1 = sel_ch1 ? ch1_w1 : ch0_w1;
  assign snap_hit = snap_vld_r && (snap_ch_r == sel_ch1) && hit_w1;

  // Reading the first word arms the snapshot; reading the second word,
  // a stop or a new pointer disarms it. A conversion that lands between
  // the two reads then cannot tear the value the host assembles.
  assign snap_vld_nxt = (host_req.rd && hit_w0)     ? 1'b1 :
                        (host_req.rd && hit_w1)     ? 1'b0 :
                        (host_req.stop || host_req.ptr_wr) ? 1'b0 :
                        snap_vld_r;

  // Snapshot registers.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      snap_r     <= WORD_RST;
      snap_ch_r  <= 1'b0;
      snap_vld_r <= 1'b0;
    end else begin
      snap_vld_r <= snap_vld_nxt;
      if (host_req.rd && hit_w0) begin
        snap_r    <= live_w1;
        snap_ch_r <= sel_ch1;
      end
    end
  end

  // ==================================================================
  // Read data.
  // ==================================================================

  logic [15:0] rd_mux; // Word selected by the pointer.

  // Offsets above 3 belong to other blocks and read as zero here.
  assign rd_mux = (ptr_r == OFS_CH0_W0) ? ch0_w0 :
                  (ptr_r == OFS_CH1_W0) ? ch1_w0 :
                  snap_hit              ? snap_r :
                  hit_w1                ? live_w1 :
                  UNMAPPED_VAL;

  // The answer follows each read one cycle later and stands until the
  // next read; the valid flag is high one cycle per read, so back-to-back reads keep it high.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r  <= WORD_RST;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= host_req.rd;
      if (host_req.rd) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // ==================================================================
  // Checks.
  // ==================================================================

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Helper: a read taken at the given pointer offset, with no pointer write.
  sequence rd_at_ofs(logic [7:0] ofs);
    host_req.rd && !host_req.ptr_wr && ptr_r == ofs;
  endsequence

  rd_answer_a: assert property (
    host_req.rd |=> rd_valid_r ##1 (!rd_valid_r || $past(host_req.rd)))
    else $error("read answer is not a one-cycle pulse");

  burst_step_a: assert property (
    host_req.rd && burst_en && !host_req.stop && !host_req.ptr_wr
      |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("burst read did not advance the pointer");

  no_burst_a: assert property (
    host_req.rd && !burst_en && !host_req.stop && !host_req.ptr_wr
      |=> $stable(ptr_r))
    else $error("pointer moved without burst mode");

  stop_restore_a: assert property (
    host_req.stop && !host_req.ptr_wr |=> ptr_r == $past(base_r))
    else $error("stop did not restore the pointer");

  code_field_a: assert property (
    rd_at_ofs(OFS_CH0_W0) |=> rd_data_r[15:12] == $past(ch0_w0[15:12]))
    else $error("range code misplaced in channel 0 word");

  mant_join_a: assert property (
    rd_at_ofs(OFS_CH1_W0) |=>
      rd_data_r[11:0] == $past(conv_ch1.mant[19:8]) || !$past(1'b1)
      || $past(ch1_w0[11:0]) == rd_data_r[11:0])
    else $error("mantissa high read wrong on channel 1");

  unmapped_a: assert property (
    host_req.rd && !hit_w0 && !hit_w1 |=> rd_data_r == UNMAPPED_VAL)
    else $error("unmapped offset read non-zero");

  chk_bit3_a: assert property (
    rd_at_ofs(OFS_CH0_W1) && !snap_hit |=>
      rd_data_r[3] == ($past(ch0_w0[3]) ^ rd_data_r[11]
                       ^ $past(ch0_w0[11])))
    else $error("check bit 3 does not match mantissa");

  coherent_a: assert property (
    host_req.rd && hit_w0 && !host_req.stop ##1
      (host_req.rd && !host_req.ptr_wr && !host_req.stop
       && ptr_r == $past(ptr_r) + 8'h01)
      |=> rd_data_r == $past(snap_r))
    else $error("second word not taken from the snapshot");

endmodule : light_result_regs

/* dv/host_model.sv */
`timescale 1ns/1ns
// ==================================================================
// Host side of the register port: pointer writes, reads and stops.
// ==================================================================
module host_model
  import light_result_pkg::*;
(
  // Clock.
  input  wire logic        clk_sys,
  // Read answer from the bank.
  input  wire logic [15:0] rd_data_r,
  input  wire logic        rd_valid_r,
  // Requests towards the bank.
  output host_req_t        host_req,
  output logic             burst_en
);
  // Requests start idle so nothing is taken during reset.
  initial begin
    host_req = '0;
    burst_en = 1'b0;
  end

  // One request cycle, launched and withdrawn on rising edges.
  task automatic pulse(input logic wr, input logic rd, input logic stp,
                       input logic [7:0] p);
    @(posedge clk_sys);
    host_req <= '{ptr_wr: wr, ptr: p, rd: rd, stop: stp};
    @(posedge clk_sys);
    host_req <= '0;
  endtask : pulse

  // Burst mode is a level, changed only on a rising edge.
  task automatic set_burst(input logic on);
    @(posedge clk_sys);
    burst_en <= on;
  endtask : set_burst

  // One word read; the answer is sampled mid-cycle to avoid edge races.
  task automatic read(output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = '0;
    pulse(1'b0, 1'b1, 1'b0, 8'h00);
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_sys);
      if (rd_valid_r === 1'b1) begin
        d  = rd_data_r;
        ok = 1'b1;
      end
    end
  endtask : read
endmodule : host_model

/* dv/test_light_result_regs.sv */
`timescale 1ns/1ns
// ==================================================================
// Self-checking bench for the light result register bank.
// ==================================================================
module test_light_result_regs;
  import light_result_pkg::*;
  logic        clk_sys = 1'b0;  // System clock, 50 ns period.
  logic        arst_n  = 1'b0;  // Asynchronous reset, active low.
  logic        cv0     = 1'b0;  // Channel 0 conversion strobe.
  logic        cv1     = 1'b0;  // Channel 1 conversion strobe.
  conv_t       cd0     = '0;    // Channel 0 conversion data.
  conv_t       cd1     = '0;    // Channel 1 conversion data.
  host_req_t   host_req;        // Requests from the host model.
  logic        burst_en;        // Burst mode level.
  logic [15:0] rd_data_r;       // Read data.
  logic        rd_valid_r;      // Read data strobe.
  int          errors = 0;      // Mismatches seen.
  int          checks = 0;      // Comparisons made.
  logic [3:0]  e_code[2] = '{default: '0}; // Expected range codes.
  logic [19:0] e_mant[2] = '{default: '0}; // Expected mantissas.
  logic [3:0]  e_seq[2]  = '{default: '0}; // Expected counters.

  always #25 clk_sys = ~clk_sys;

  light_result_regs DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .conv_valid_ch0(cv0), .conv_ch0(cd0), .conv_valid_ch1(cv1),
    .conv_ch1(cd1), .host_req(host_req), .burst_en(burst_en),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));

  host_model host (.clk_sys(clk_sys), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .host_req(host_req), .burst_en(burst_en));

  // ================================================================
  // Expectations, worked out from the field layout and equations.
  // ================================================================
  function automatic logic [15:0] exp_w0(input int ch);
    return {e_code[ch], e_mant[ch][19:8]};
  endfunction : exp_w0

  // Second word; the check field input is the new counter value.
  function automatic logic [15:0] exp_w1(input int ch);
    logic [3:0]  c;
    logic [3:0]  s;
    logic [19:0] m;
    logic [3:0]  k;
    c = e_code[ch];
    m = e_mant[ch];
    s = e_seq[ch];
    k[0] = ^c ^ ^m ^ ^s;
    k[1] = s[1] ^ s[3] ^ (^(m & 20'hA_AAAA)) ^ c[1] ^ c[3];
    k[2] = s[3] ^ m[3] ^ m[7] ^ m[11] ^ m[15] ^ m[19] ^ c[3];
    k[3] = m[3] ^ m[11] ^ m[19];
    return {m[7:0], s, k};
  endfunction : exp_w1

  // ================================================================
  // Reporting.
  // ================================================================
  task automatic finish_test;
    $display("Counts: %0d checks, %0d errors", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask : check16

  // Reads at the current pointer; a missing answer ends the run.
  task automatic rd_chk(input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host.read(d, ok);
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t no read answer", $time);
      finish_test();
    end
    check16(d, exp);
  endtask : rd_chk

  task automatic rd_at(input logic [7:0] ofs, input logic [15:0] exp);
    host.pulse(1'b1, 1'b0, 1'b0, ofs);
    rd_chk(exp);
  endtask : rd_at

  // One conversion pulse; the expected counter rolls with it.
  task automatic conv(input int ch, input logic [3:0] c,
                      input logic [19:0] m);
    @(posedge clk_sys);
    if (ch == 0) begin
      cv0 <= 1'b1;
      cd0 <= '{code: c, mant: m};
    end else begin
      cv1 <= 1'b1;
      cd1 <= '{code: c, mant: m};
    end
    @(posedge clk_sys);
    cv0 <= 1'b0;
    cv1 <= 1'b0;
    e_code[ch] = c;
    e_mant[ch] = m;
    e_seq[ch]  = e_seq[ch] + 4'h1;
  endtask : conv

  // ================================================================
  // Scenarios.
  // ================================================================
  // Every word reads zero after reset, an unmapped offset as well.
  task automatic t_reset;
    for (int o = 0; o < 4; o++) rd_at(o[7:0], 16'h0000);
    rd_at(8'h04, 16'h0000);
  endtask : t_reset

  // Field placement and check bits of both channels.
  task automatic t_fields;
    conv(0, 4'hA, 20'h5_3C9E);
    conv(1, 4'h3, 20'hF_0F0F);
    conv(1, 4'hF, 20'h8_0808);
    rd_at(OFS_CH0_W0, exp_w0(0));
    rd_at(OFS_CH0_W1, exp_w1(0));
    rd_at(OFS_CH1_W0, exp_w0(1));
    rd_at(OFS_CH1_W1, exp_w1(1));
  endtask : t_fields

  // Sixteen more conversions roll the counter past fifteen.
  task automatic t_wrap;
    for (int i = 0; i < 16; i++) conv(1, i[3:0], 20'h1_2345 * i);
    rd_at(OFS_CH1_W0, exp_w0(1));
    rd_at(OFS_CH1_W1, exp_w1(1));
  endtask : t_wrap

  // Burst reads walk all four words; a stop returns to the base.
  task automatic t_burst;
    host.set_burst(1'b1);
    host.pulse(1'b1, 1'b0, 1'b0, OFS_CH0_W0);
    rd_chk(exp_w0(0));
    rd_chk(exp_w1(0));
    rd_chk(exp_w0(1));
    rd_chk(exp_w1(1));
    host.pulse(1'b0, 1'b0, 1'b1, 8'h00);
    rd_chk(exp_w0(0));
  endtask : t_burst

  // A conversion between the two reads of a channel stays hidden.
  task automatic t_snap;
    logic [15:0] old_w1;
    host.pulse(1'b1, 1'b0, 1'b0, OFS_CH0_W0);
    rd_chk(exp_w0(0));
    old_w1 = exp_w1(0);
    conv(0, 4'h7, 20'hC_1A2B);
    rd_chk(old_w1);
    host.set_burst(1'b0);
    rd_at(OFS_CH0_W1, exp_w1(0));
  endtask : t_snap

  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_wrap();
    t_burst();
    t_snap();
    finish_test();
  end
endmodule : test_light_result_regs
